// [hw/sprhc_top.sv]
// Packet framing, air-time arithmetic and hop sequencing of the spread-spectrum modem.
//
// Behaviour
// - Preamble length is 12 after reset.
// - Preamble setting 6..65535, sent with 4 extra.
// - No-header select bit picks header type.
// - Explicit header carries length, rate, CRC flag.
// - Header coded 4/8; bad header CRC discarded.
// - Implicit mode sends no header; ends preconfigured.
// - Spreading factor 6 forces headerless framing.
// - Preamble time is count plus 4.25 symbols.
// - Payload symbols follow the ceiling formula.
// - Non-zero dwell field enables hopping.
// - Dwell equals symbol period times dwell field.
// - Transmit starts on channel 0 through header.
// - Each hop bumps index and raises flag.
// - Receive starts channel 0, hops after header.
// - Header CRC failure returns to channel 0.
// - Settings kept in FSK; auto sequencer only in FSK.
// - Packet RAM reachable only in spread mode.
// - RAM unreadable in sleep, cleared entering receive.
// - Symbol lasts two to spreading-factor chips.
// - Each buffer port access advances the pointer except in sleep, FSK, a pointer-write cycle or the clear on entering receive.
`timescale 1ns/1ps
`default_nettype none
`include "sprhc_cfg.svh"
module sprhc_top (
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic                   link_clk,
	input  wire logic                   fsk_mode,
	input  wire sprhc_pkg::sprhc_mode_t op_mode,
	input  wire logic                   auto_top_sequencer_req,
	input  wire logic                   cfg_we,
	input  wire logic [7:0]             cfg_preamble_len_high,
	input  wire logic [7:0]             cfg_preamble_len_low,
	input  wire logic                   cfg_no_header_select,
	input  wire logic [3:0]             cfg_spread_factor,
	input  wire logic [2:0]             cfg_coding_rate_code,
	input  wire logic                   cfg_crc_on,
	input  wire logic [7:0]             cfg_payload_len,
	input  wire logic                   cfg_slow_rate_robustness,
	input  wire logic [7:0]             cfg_hop_dwell_field,
	input  wire logic                   irq_clr_we,
	input  wire logic                   irq_clr_data,
	input  wire logic                   buffer_pointer_we,
	input  wire logic [7:0]             buffer_pointer_wdata,
	input  wire logic                   buffer_port_wr,
	input  wire logic                   buffer_port_rd,
	input  wire logic [7:0]             buffer_port_wdata,
	input  wire logic                   rx_byte_we,
	input  wire logic [7:0]             rx_byte_addr,
	input  wire logic [7:0]             rx_byte_data,
	input  wire logic                   link_preamble_ok,
	input  wire logic                   link_hdr_ok,
	input  wire logic                   link_hdr_err,
	output logic [7:0]                  buffer_port_rdata,
	output logic [7:0]                  buffer_pointer,
	output logic [15:0]                 preamble_len_setting,
	output logic                        no_header_select,
	output logic [16:0]                 tx_preamble_syms,
	output logic                        hdr_enable,
	output logic [7:0]                  hdr_payload_len,
	output logic [2:0]                  hdr_coding_rate_code,
	output logic                        hdr_crc_flag,
	output logic [2:0]                  hdr_enc_rate,
	output logic [15:0]                 pay_syms,
	output logic [19:0]                 toa_qsym,
	output logic                        hopping_on,
	output logic [5:0]                  current_hop_index,
	output logic                        hop_change_irq,
	output logic                        auto_top_sequencer_en,
	output logic                        link_sym_tick,
	output logic                        link_in_preamble,
	output logic                        link_hop,
	output logic                        link_hdr_discard
);
	sprhc_pkg::sprhc_core_t q_r;
	sprhc_pkg::sprhc_core_t q_nxt;
	sprhc_pkg::sprhc_link_t l_r;
	sprhc_pkg::sprhc_link_t l_nxt;
	logic        hop_s;
	logic        c0_s;
	logic        run_ls;
	logic        hdrless;
	logic        hop_ev;
	logic [15:0] wlen;
	logic [13:0] num;
	logic [13:0] numu;
	logic [5:0]  den;
	logic [7:0]  quo;
	logic [15:0] pay;
	logic [11:0] slen;
	logic        tick;

	sprhc_buf_if bif ();

	////////////////////////////////////////////////////////////////////////////
	// Crossings. Configuration words are read by the link side unsynchronised;
	// writes are not blocked while the run level is high; only the transmit select is held then.
	sprhc_sync u_run (
		.clk     (link_clk),
		.sys_rst (sys_rst),
		.d       (q_r.run),
		.q       (run_ls)
	);
	sprhc_sync u_hop (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       (l_r.hop_tog),
		.q       (hop_s)
	);
	sprhc_sync u_c0 (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       (l_r.c0_tog),
		.q       (c0_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// Core domain: settings, air-time arithmetic, hop index and flag.
	always_comb begin
		q_nxt = q_r;
		wlen = {cfg_preamble_len_high, cfg_preamble_len_low};
		hdrless = q_r.no_hdr | (q_r.spread_factor == `SPRHC_SPREAD_NOHDR);
		num = {3'h0, q_r.pl, 3'h0} - {8'h00, q_r.spread_factor, 2'h0}
			+ `SPRHC_TOA_K28 + `SPRHC_TOA_K16
			- (hdrless ? `SPRHC_TOA_K20 : 14'h0000);
		den = {q_r.spread_factor - {2'h0, q_r.slow, 1'b0}, 2'b00};
		numu = num + {8'h00, den} - 14'h0001;
		if (!num[13] && num != 14'h0000 && den != 6'h00) begin
			quo = 8'(numu / {8'h00, den});
		end else begin
			quo = 8'h00;
		end
		pay = `SPRHC_PAY_BASE + 16'(quo) * 16'({1'b0, q_r.coding_rate_code} + 4'h4);
		q_nxt.pay = pay;
		q_nxt.toa = {2'h0, q_r.pre_len, 2'h0} + `SPRHC_PRE_QTR_X4 + {2'h0, pay, 2'h0};
		q_nxt.tx_pre = {1'b0, q_r.pre_len} + `SPRHC_PRE_OVH;
		q_nxt.hdr_en = !hdrless;
		q_nxt.hdr_len = q_r.pl;
		q_nxt.hdr_cr = q_r.coding_rate_code;
		q_nxt.hdr_crc = q_r.crc_on;
		q_nxt.hdr_enc = `SPRHC_HDR_RATE;
		q_nxt.hop_on = q_r.dwell != 8'h00;
		q_nxt.ats = auto_top_sequencer_req & fsk_mode;
		if (cfg_we && !fsk_mode) begin
			q_nxt.pre_len = (wlen < `SPRHC_PRE_MIN) ? `SPRHC_PRE_MIN : wlen;
			q_nxt.no_hdr = cfg_no_header_select;
			q_nxt.spread_factor = cfg_spread_factor;
			q_nxt.coding_rate_code = cfg_coding_rate_code;
			q_nxt.crc_on = cfg_crc_on;
			q_nxt.pl = cfg_payload_len;
			q_nxt.slow = cfg_slow_rate_robustness;
			q_nxt.dwell = cfg_hop_dwell_field;
		end
		q_nxt.mode_q = op_mode;
		q_nxt.run = !fsk_mode && (op_mode == sprhc_pkg::SPRHC_TX
			|| op_mode == sprhc_pkg::SPRHC_RX) && (op_mode == q_r.mode_q);
		if (!q_r.run) begin
			q_nxt.tx_sel = op_mode == sprhc_pkg::SPRHC_TX;
		end
		q_nxt.hop_q = hop_s;
		q_nxt.c0_q = c0_s;
		hop_ev = hop_s ^ q_r.hop_q;
		if ((q_nxt.run && !q_r.run) || (c0_s ^ q_r.c0_q)) begin
			q_nxt.hop_idx = 6'h00;
		end else if (hop_ev) begin
			q_nxt.hop_idx = q_r.hop_idx + 6'h01;
		end
		// A hop arriving with the clear keeps the flag set.
		q_nxt.irq = hop_ev | (q_r.irq & !(irq_clr_we & irq_clr_data));
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			q_r         <= '0;
			q_r.pre_len <= `SPRHC_PRE_RST;
			q_r.tx_pre  <= {1'b0, `SPRHC_PRE_RST} + `SPRHC_PRE_OVH;
			q_r.hdr_en  <= 1'b1;
		end else begin
			q_r <= q_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link domain: chip counting, frame phases and hop timing.
	always_comb begin
		l_nxt = l_r;
		slen = 12'((13'h0001 << q_r.spread_factor) - 13'h0001);
		tick = l_r.chip == slen;
		l_nxt.hop_p = 1'b0;
		l_nxt.disc = 1'b0;
		l_nxt.tick = tick && (l_r.st != sprhc_pkg::LK_IDLE);
		l_nxt.chip = tick ? 12'h000 : l_r.chip + 12'h001;
		case (l_r.st)
			sprhc_pkg::LK_IDLE: begin
				l_nxt.chip = 12'h000;
				l_nxt.sym = 17'h00000;
				l_nxt.dwl = 8'h00;
				if (run_ls) begin
					l_nxt.st = q_r.tx_sel ? sprhc_pkg::LK_PRE : sprhc_pkg::LK_WAIT;
				end
			end
			sprhc_pkg::LK_PRE: begin
				if (tick) begin
					l_nxt.sym = l_r.sym + 17'h00001;
					if (l_nxt.sym == {1'b0, q_r.pre_len} + `SPRHC_PRE_OVH) begin
						l_nxt.st = sprhc_pkg::LK_QTR;
						l_nxt.chip = 12'h000;
					end
				end
			end
			sprhc_pkg::LK_QTR: begin
				if (l_r.chip == {2'h0, slen[11:2]}) begin
					l_nxt.st = sprhc_pkg::LK_HDR;
					l_nxt.chip = 12'h000;
					l_nxt.sym = 17'h00000;
				end
			end
			sprhc_pkg::LK_WAIT: begin
				l_nxt.chip = 12'h000;
				l_nxt.sym = 17'h00000;
				if (link_preamble_ok) begin
					l_nxt.st = sprhc_pkg::LK_HDR;
				end
			end
			sprhc_pkg::LK_HDR: begin
				if (!q_r.tx_sel && q_r.hdr_en) begin
					if (link_hdr_err) begin
						l_nxt.st = sprhc_pkg::LK_WAIT;
						l_nxt.c0_tog = !l_r.c0_tog;
						l_nxt.disc = 1'b1;
					end else if (link_hdr_ok) begin
						l_nxt.st = sprhc_pkg::LK_PAY;
						l_nxt.chip = 12'h000;
						l_nxt.sym = `SPRHC_HDR_SYMS;
						l_nxt.dwl = 8'h00;
					end
				end else if (tick) begin
					l_nxt.sym = l_r.sym + 17'h00001;
					if (l_nxt.sym == `SPRHC_HDR_SYMS) begin
						l_nxt.st = sprhc_pkg::LK_PAY;
						l_nxt.dwl = 8'h00;
					end
				end
			end
			sprhc_pkg::LK_PAY: begin
				if (l_r.sym >= {1'b0, q_r.pay}) begin
					l_nxt.st = sprhc_pkg::LK_DONE;
				end else if (tick) begin
					l_nxt.sym = l_r.sym + 17'h00001;
					if (q_r.dwell != 8'h00) begin
						if (l_r.dwl == q_r.dwell - 8'h01) begin
							l_nxt.dwl = 8'h00;
							l_nxt.hop_tog = !l_r.hop_tog;
							l_nxt.hop_p = 1'b1;
						end else begin
							l_nxt.dwl = l_r.dwl + 8'h01;
						end
					end
				end
			end
			sprhc_pkg::LK_DONE: begin
				l_nxt.chip = 12'h000;
			end
			default: begin
				l_nxt.st = sprhc_pkg::LK_IDLE;
			end
		endcase
		if (!run_ls) begin
			l_nxt.st = sprhc_pkg::LK_IDLE;
		end
		l_nxt.in_pre = (l_nxt.st == sprhc_pkg::LK_PRE) || (l_nxt.st == sprhc_pkg::LK_QTR);
	end

	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			l_r    <= '0;
			l_r.st <= sprhc_pkg::LK_IDLE;
		end else begin
			l_r <= l_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Packet RAM and outputs.
	assign bif.clr = op_mode == sprhc_pkg::SPRHC_SLEEP
		|| (op_mode == sprhc_pkg::SPRHC_RX && q_r.mode_q != sprhc_pkg::SPRHC_RX);
	assign bif.access = !fsk_mode && op_mode != sprhc_pkg::SPRHC_SLEEP;
	assign bif.ptr_we = buffer_pointer_we;
	assign bif.ptr_wdata = buffer_pointer_wdata;
	assign bif.wr = buffer_port_wr;
	assign bif.rd = buffer_port_rd;
	assign bif.wdata = buffer_port_wdata;
	assign bif.rx_we = rx_byte_we;
	assign bif.rx_addr = rx_byte_addr;
	assign bif.rx_data = rx_byte_data;

	sprhc_buf u_buf (
		.clk     (clk),
		.sys_rst (sys_rst),
		.bp      (bif.mem)
	);

	assign buffer_port_rdata     = bif.rdata;
	assign buffer_pointer        = bif.ptr;
	assign preamble_len_setting  = q_r.pre_len;
	assign no_header_select      = q_r.no_hdr;
	assign tx_preamble_syms      = q_r.tx_pre;
	assign hdr_enable            = q_r.hdr_en;
	assign hdr_payload_len       = q_r.hdr_len;
	assign hdr_coding_rate_code  = q_r.hdr_cr;
	assign hdr_crc_flag          = q_r.hdr_crc;
	assign hdr_enc_rate          = q_r.hdr_enc;
	assign pay_syms              = q_r.pay;
	assign toa_qsym              = q_r.toa;
	assign hopping_on            = q_r.hop_on;
	assign current_hop_index     = q_r.hop_idx;
	assign hop_change_irq        = q_r.irq;
	assign auto_top_sequencer_en = q_r.ats;
	assign link_sym_tick         = l_r.tick;
	assign link_in_preamble      = l_r.in_pre;
	assign link_hop              = l_r.hop_p;
	assign link_hdr_discard      = l_r.disc;
endmodule : sprhc_top
`default_nettype wire

// [hw/sprhc_cfg.svh]
// Offsets-free configuration constants: reset values, field limits and timing counts.
`ifndef SPRHC_CFG_SVH
`define SPRHC_CFG_SVH
`define SPRHC_PRE_RST       16'h000C
`define SPRHC_PRE_MIN       16'h0006
`define SPRHC_PRE_OVH       17'h00004
`define SPRHC_PRE_QTR_X4    20'h00011
`define SPRHC_PAY_BASE      16'h0008
`define SPRHC_HDR_SYMS      17'h00008
`define SPRHC_TOA_K28       14'h001C
`define SPRHC_TOA_K16       14'h0010
`define SPRHC_TOA_K20       14'h0014
`define SPRHC_HDR_RATE      3'h4
`define SPRHC_SPREAD_NOHDR  4'h6
`endif

// [hw/sprhc_pkg.sv]
// Types shared by the packet hop controller modules.
package sprhc_pkg;
	typedef enum logic [1:0] {
		SPRHC_SLEEP = 2'h0,
		SPRHC_STDBY = 2'h1,
		SPRHC_TX    = 2'h2,
		SPRHC_RX    = 2'h3
	} sprhc_mode_t;

	typedef enum logic [6:0] {
		LK_IDLE = 7'h01,
		LK_PRE  = 7'h02,
		LK_QTR  = 7'h04,
		LK_WAIT = 7'h08,
		LK_HDR  = 7'h10,
		LK_PAY  = 7'h20,
		LK_DONE = 7'h40
	} sprhc_lstate_t;

	typedef struct packed {
		logic [15:0] pre_len;
		logic        no_hdr;
		logic [3:0]  spread_factor;
		logic [2:0]  coding_rate_code;
		logic        crc_on;
		logic [7:0]  pl;
		logic        slow;
		logic [7:0]  dwell;
		sprhc_mode_t mode_q;
		logic        run;
		logic        tx_sel;
		logic        hop_q;
		logic        c0_q;
		logic [5:0]  hop_idx;
		logic        irq;
		logic        hop_on;
		logic        ats;
		logic [15:0] pay;
		logic [19:0] toa;
		logic [16:0] tx_pre;
		logic        hdr_en;
		logic [7:0]  hdr_len;
		logic [2:0]  hdr_cr;
		logic        hdr_crc;
		logic [2:0]  hdr_enc;
	} sprhc_core_t;

	typedef struct packed {
		sprhc_lstate_t st;
		logic [11:0]   chip;
		logic [16:0]   sym;
		logic [7:0]    dwl;
		logic          hop_tog;
		logic          c0_tog;
		logic          tick;
		logic          in_pre;
		logic          hop_p;
		logic          disc;
	} sprhc_link_t;

	typedef struct packed {
		logic [255:0][7:0] mem;
		logic [7:0]        ptr;
		logic [7:0]        rdata;
	} sprhc_buf_t;

	typedef struct packed {
		logic s1;
		logic s2;
	} sprhc_sync_t;
endpackage : sprhc_pkg

// [hw/sprhc_buf_if.sv]
// Carrier between the controller and its packet RAM.
`timescale 1ns/1ps
`default_nettype none
interface sprhc_buf_if;
	logic       clr;
	logic       access;
	logic       ptr_we;
	logic [7:0] ptr_wdata;
	logic       wr;
	logic       rd;
	logic [7:0] wdata;
	logic       rx_we;
	logic [7:0] rx_addr;
	logic [7:0] rx_data;
	logic [7:0] rdata;
	logic [7:0] ptr;
	modport ctl (output clr, access, ptr_we, ptr_wdata, wr, rd, wdata,
		rx_we, rx_addr, rx_data, input rdata, ptr);
	modport mem (input clr, access, ptr_we, ptr_wdata, wr, rd, wdata,
		rx_we, rx_addr, rx_data, output rdata, ptr);
endinterface : sprhc_buf_if
`default_nettype wire

// [hw/sprhc_sync.sv]
// Two-flop level synchroniser.
`timescale 1ns/1ps
`default_nettype none
module sprhc_sync (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic d,
	output var  logic q
);
	sprhc_pkg::sprhc_sync_t s_r;
	sprhc_pkg::sprhc_sync_t s_nxt;

	always_comb begin
		s_nxt    = s_r;
		s_nxt.s1 = d;
		s_nxt.s2 = s_r.s1;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.s2;
endmodule : sprhc_sync
`default_nettype wire

// [hw/sprhc_buf.sv]
// Packet RAM of 256 bytes with an auto-advancing host pointer.
`timescale 1ns/1ps
`default_nettype none
module sprhc_buf (
	input  wire logic  clk,
	input  wire logic  sys_rst,
	sprhc_buf_if.mem   bp
);
	sprhc_pkg::sprhc_buf_t b_r;
	sprhc_pkg::sprhc_buf_t b_nxt;

	// Clearing all bytes at once costs area but keeps stale packets invisible at once.
	always_comb begin
		b_nxt = b_r;
		if (bp.clr) begin
			b_nxt.mem = '0;
		end else begin
			if (bp.rx_we && bp.access) begin
				b_nxt.mem[bp.rx_addr] = bp.rx_data;
			end
			if (bp.ptr_we) begin
				b_nxt.ptr = bp.ptr_wdata;
			end else if (bp.wr && bp.access) begin
				b_nxt.mem[b_r.ptr] = bp.wdata;
				b_nxt.ptr = b_r.ptr + 8'h01;
			end else if (bp.rd && bp.access) begin
				b_nxt.rdata = b_r.mem[b_r.ptr];
				b_nxt.ptr = b_r.ptr + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			b_r <= '0;
		end else begin
			b_r <= b_nxt;
		end
	end

	assign bp.rdata = b_r.rdata;
	assign bp.ptr   = b_r.ptr;
endmodule : sprhc_buf
`default_nettype wire

// [bench/sprhc_chk.sv]
// Port assertions for the packet hop controller.
`timescale 1ns/1ps
`default_nettype none
module sprhc_chk (
	input wire logic			clk,
	input wire logic			sys_rst,
	input wire logic			fsk_mode,
	input wire sprhc_pkg::sprhc_mode_t	op_mode,
	input wire logic			cfg_we,
	input wire logic			cfg_no_header_select,
	input wire logic [3:0]		cfg_spread_factor,
	input wire logic [7:0]		cfg_hop_dwell_field,
	input wire logic			irq_clr_we,
	input wire logic			irq_clr_data,
	input wire logic			buffer_pointer_we,
	input wire logic			buffer_port_wr,
	input wire logic			buffer_port_rd,
	input wire logic [7:0]		buffer_pointer,
	input wire logic [15:0]		preamble_len_setting,
	input wire logic [16:0]		tx_preamble_syms,
	input wire logic			hdr_enable,
	input wire logic [2:0]		hdr_enc_rate,
	input wire logic			hopping_on,
	input wire logic [5:0]		current_hop_index,
	input wire logic			hop_change_irq,
	input wire logic			auto_top_sequencer_en
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic	step_ok;
	assign step_ok = !fsk_mode && op_mode != sprhc_pkg::SPRHC_SLEEP && !buffer_pointer_we
		&& (buffer_port_rd || buffer_port_wr);
	////////////////////////////////////////
	a_pre_reset: assert property ($fell(sys_rst) |-> preamble_len_setting == 16'h000C)
		else $error("reset preamble length");
	a_pre_sum: assert property (
		tx_preamble_syms == {1'b0, $past(preamble_len_setting)} + 17'h00004)
		else $error("preamble sum");
	a_hdr_off: assert property (cfg_we && !fsk_mode &&
		(cfg_no_header_select || cfg_spread_factor == 4'h6) |-> ##2 !hdr_enable)
		else $error("header not off");
	a_hdr_rate: assert property (cfg_we && !fsk_mode |-> ##2 hdr_enc_rate == 3'h4)
		else $error("header rate");
	a_hop_en: assert property (cfg_we && !fsk_mode |-> ##2
		hopping_on == ($past(cfg_hop_dwell_field, 2) != 8'h00))
		else $error("hop enable");
	a_irq_hold: assert property (hop_change_irq && !(irq_clr_we && irq_clr_data)
		|=> hop_change_irq)
		else $error("hop flag dropped");
	a_irq_index: assert property ($rose(hop_change_irq) |->
		current_hop_index == $past(current_hop_index) + 6'h01)
		else $error("hop index step");
	a_buf_step: assert property (step_ok |=>
		buffer_pointer == $past(buffer_pointer) + 8'h01)
		else $error("pointer step");
	a_buf_lock: assert property (!step_ok && !buffer_pointer_we |=>
		$stable(buffer_pointer))
		else $error("pointer moved");
	a_ats_off: assert property (!fsk_mode |=> !auto_top_sequencer_en)
		else $error("sequencer enabled");
	c_hop: cover property ($rose(hop_change_irq));
	c_sf6: cover property (cfg_we && cfg_spread_factor == 4'h6);
	c_sleep_rd: cover property (buffer_port_rd && op_mode == sprhc_pkg::SPRHC_SLEEP);
endmodule : sprhc_chk
////////////////////////////////////////
bind sprhc_top sprhc_chk i_sprhc_chk (.*);
`default_nettype wire

// [bench/sprhc_link_peer.sv]
// Demodulator front end model reporting preamble and header events on the chip clock.
`timescale 1ns/1ps
`default_nettype none
module sprhc_link_peer (
	input wire logic	link_clk,
	output var logic	link_preamble_ok,
	output var logic	link_hdr_ok,
	output var logic	link_hdr_err
);
	initial {link_hdr_err, link_hdr_ok, link_preamble_ok} = 3'h0;
	////////////////////////////////////////
	// Header events only follow a preamble.
	task automatic pulse(input logic [2:0] ev, input int gap);
		repeat (gap) @(posedge link_clk);
		#1;
		{link_hdr_err, link_hdr_ok, link_preamble_ok} = ev;
		@(posedge link_clk);
		#1;
		{link_hdr_err, link_hdr_ok, link_preamble_ok} = 3'h0;
	endtask : pulse
endmodule : sprhc_link_peer
`default_nettype wire

// [bench/sprhc_top_tb.sv]
// Self-checking bench for the packet hop controller.
`timescale 1ns/1ps
`default_nettype none
module sprhc_top_tb;
	logic			clk, sys_rst, link_clk, fsk_mode, auto_top_sequencer_req, cfg_we;
	sprhc_pkg::sprhc_mode_t	op_mode;
	logic [7:0]		cfg_preamble_len_high, cfg_preamble_len_low, cfg_payload_len;
	logic [7:0]		cfg_hop_dwell_field, buffer_pointer_wdata, buffer_port_wdata;
	logic [7:0]		rx_byte_addr, rx_byte_data, buffer_port_rdata, buffer_pointer;
	logic [7:0]		hdr_payload_len;
	logic			cfg_no_header_select, cfg_crc_on, cfg_slow_rate_robustness;
	logic			irq_clr_we, irq_clr_data, buffer_pointer_we, buffer_port_wr;
	logic			buffer_port_rd, rx_byte_we, link_preamble_ok, link_hdr_ok, link_hdr_err;
	logic			no_header_select, hdr_enable, hdr_crc_flag, hopping_on, hop_change_irq;
	logic			auto_top_sequencer_en, link_sym_tick, link_in_preamble, link_hop;
	logic			link_hdr_discard;
	logic [3:0]		cfg_spread_factor;
	logic [2:0]		cfg_coding_rate_code, hdr_coding_rate_code, hdr_enc_rate;
	logic [15:0]		preamble_len_setting, pay_syms;
	logic [16:0]		tx_preamble_syms;
	logic [19:0]		toa_qsym;
	logic [5:0]		current_hop_index;
	int			mismatches, samples_checked, waited, discards;
	sprhc_top i_sprhc_top (.clk, .sys_rst, .link_clk, .fsk_mode, .op_mode,
		.auto_top_sequencer_req, .cfg_we, .cfg_preamble_len_high, .cfg_preamble_len_low,
		.cfg_no_header_select, .cfg_spread_factor, .cfg_coding_rate_code, .cfg_crc_on,
		.cfg_payload_len, .cfg_slow_rate_robustness, .cfg_hop_dwell_field, .irq_clr_we,
		.irq_clr_data, .buffer_pointer_we, .buffer_pointer_wdata, .buffer_port_wr,
		.buffer_port_rd, .buffer_port_wdata, .rx_byte_we, .rx_byte_addr, .rx_byte_data,
		.link_preamble_ok, .link_hdr_ok, .link_hdr_err, .buffer_port_rdata, .buffer_pointer,
		.preamble_len_setting, .no_header_select, .tx_preamble_syms, .hdr_enable,
		.hdr_payload_len, .hdr_coding_rate_code, .hdr_crc_flag, .hdr_enc_rate, .pay_syms,
		.toa_qsym, .hopping_on, .current_hop_index, .hop_change_irq, .auto_top_sequencer_en,
		.link_sym_tick, .link_in_preamble, .link_hop, .link_hdr_discard);
	sprhc_link_peer i_sprhc_link_peer (.link_clk, .link_preamble_ok, .link_hdr_ok,
		.link_hdr_err);
	always #50 clk = ~clk;
	always #7.5 link_clk = ~link_clk;
	always @(posedge link_clk) begin
		if (link_hdr_discard === 1'b1) discards++;
	end
	////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic wait_lvl(ref logic s, input logic v, input int lim);
		waited = 0;
		while (s !== v && waited < lim) begin
			step(1);
			waited++;
		end
		if (waited >= lim) chk("wait", 20'h1, 20'h0);
	endtask : wait_lvl
	task automatic cfg(input logic [15:0] pre, input logic nh, input logic [3:0] sf,
		input logic [2:0] cr, input logic [7:0] pl, input logic slow, input logic [7:0] dw);
		{cfg_preamble_len_high, cfg_preamble_len_low} = pre;
		{cfg_no_header_select, cfg_spread_factor, cfg_coding_rate_code} = {nh, sf, cr};
		{cfg_payload_len, cfg_slow_rate_robustness, cfg_hop_dwell_field} = {pl, slow, dw};
		cfg_crc_on = 1'b1;
		cfg_we = 1'b1;
		step(1);
		cfg_we = 1'b0;
		step(3);
	endtask : cfg
	function automatic int pay_exp(input int pl, sf, cr, h, de);
		int n;
		int d;
		n = 8 * pl - 4 * sf + 44 - 20 * h;
		d = 4 * (sf - 2 * de);
		return (n <= 0) ? 8 : 8 + ((n + d - 1) / d) * (cr + 4);
	endfunction : pay_exp
	task automatic clr(input logic d);
		{irq_clr_we, irq_clr_data} = {1'b1, d};
		step(1);
		irq_clr_we = 1'b0;
		step(1);
	endtask : clr
	task automatic ptr_load(input logic [7:0] a);
		{buffer_pointer_we, buffer_pointer_wdata} = {1'b1, a};
		step(1);
		buffer_pointer_we = 1'b0;
	endtask : ptr_load
	task automatic rd1(input logic [7:0] exp);
		buffer_port_rd = 1'b1;
		step(1);
		buffer_port_rd = 1'b0;
		chk("rdata", exp, buffer_port_rdata);
		step(1);
	endtask : rd1
	////////////////////////////////////////
	task automatic t_reset;
		chk("preamble_len_setting", 20'h0000C, preamble_len_setting);
		chk("tx_preamble_syms", 20'h00010, tx_preamble_syms);
		chk("hdr_enable", 20'h1, hdr_enable);
		chk("hopping_on", 20'h0, hopping_on);
	endtask : t_reset
	task automatic t_header;
		cfg(16'h0003, 1'b0, 4'h7, 3'h1, 8'h0A, 1'b0, 8'h00);
		chk("preamble_len_setting", 20'h6, preamble_len_setting);
		chk("hdr_fields", 20'h0851C, {hdr_enable, hdr_payload_len, hdr_coding_rate_code,
			hdr_crc_flag, hdr_enc_rate});
		cfg(16'hFFFF, 1'b1, 4'h7, 3'h1, 8'h0A, 1'b0, 8'h00);
		chk("tx_preamble_syms", 20'h10003, tx_preamble_syms);
		chk("no_header", 20'h2, {no_header_select, hdr_enable});
		cfg(16'h000C, 1'b0, 4'h6, 3'h1, 8'h0A, 1'b0, 8'h00);
		chk("hdr_enable", 20'h0, hdr_enable);
	endtask : t_header
	task automatic t_airtime;
		int tpre[4] = '{6, 12, 1000, 65535};
		int tpl[4] = '{10, 0, 255, 40};
		int tsf[4] = '{7, 12, 12, 9};
		int tcr[4] = '{1, 4, 2, 3};
		int th[4] = '{0, 1, 0, 1};
		int tde[4] = '{0, 0, 1, 1};
		int p;
		for (int i = 0; i < 4; i++) begin
			cfg(16'(tpre[i]), th[i][0], 4'(tsf[i]), 3'(tcr[i]), 8'(tpl[i]), tde[i][0], 8'h00);
			p = pay_exp(tpl[i], tsf[i], tcr[i], th[i], tde[i]);
			chk("pay_syms", 20'(p), pay_syms);
			chk("toa_qsym", 20'(4 * tpre[i] + 17 + 4 * p), toa_qsym);
		end
	endtask : t_airtime
	task automatic t_fsk;
		cfg(16'h0064, 1'b0, 4'h7, 3'h1, 8'h0A, 1'b0, 8'h00);
		{fsk_mode, auto_top_sequencer_req} = 2'h3;
		cfg(16'h0014, 1'b0, 4'h7, 3'h1, 8'h0A, 1'b0, 8'h00);
		chk("preamble_len_setting", 20'h64, preamble_len_setting);
		chk("auto_top_sequencer_en", 20'h1, auto_top_sequencer_en);
		fsk_mode = 1'b0;
		step(2);
		chk("auto_top_sequencer_en", 20'h0, auto_top_sequencer_en);
		auto_top_sequencer_req = 1'b0;
	endtask : t_fsk
	task automatic t_buffer;
		op_mode = sprhc_pkg::SPRHC_STDBY;
		ptr_load(8'h05);
		buffer_port_wr = 1'b1;
		for (int i = 0; i < 3; i++) begin
			buffer_port_wdata = 8'(8'hA0 + i);
			step(1);
		end
		buffer_port_wr = 1'b0;
		chk("pointer", 20'h8, buffer_pointer);
		{rx_byte_we, rx_byte_addr, rx_byte_data} = {1'b1, 8'h08, 8'h5A};
		step(1);
		rx_byte_we = 1'b0;
		ptr_load(8'h05);
		for (int i = 0; i < 4; i++) rd1((i < 3) ? 8'(8'hA0 + i) : 8'h5A);
		op_mode = sprhc_pkg::SPRHC_SLEEP;
		step(2);
		rd1(8'h5A);
		chk("pointer", 20'h9, buffer_pointer);
		op_mode = sprhc_pkg::SPRHC_STDBY;
		ptr_load(8'h05);
		rd1(8'h00);
		ptr_load(8'h05);
		{buffer_port_wr, buffer_port_wdata} = {1'b1, 8'h77};
		step(1);
		buffer_port_wr = 1'b0;
		op_mode = sprhc_pkg::SPRHC_RX;
		step(1);
		op_mode = sprhc_pkg::SPRHC_STDBY;
		ptr_load(8'h05);
		rd1(8'h00);
	endtask : t_buffer
	task automatic t_hop_tx;
		cfg(16'h0006, 1'b1, 4'h6, 3'h4, 8'h28, 1'b0, 8'h02);
		chk("hopping_on", 20'h1, hopping_on);
		op_mode = sprhc_pkg::SPRHC_TX;
		wait_lvl(link_in_preamble, 1'b1, 20);
		chk("index", 20'h0, current_hop_index);
		wait_lvl(link_in_preamble, 1'b0, 200);
		step(40);
		chk("hop_flag", 20'h0, hop_change_irq);
		wait_lvl(hop_change_irq, 1'b1, 300);
		chk("index", 20'h1, current_hop_index);
		clr(1'b0);
		chk("hop_flag", 20'h1, hop_change_irq);
		clr(1'b1);
		chk("hop_flag", 20'h0, hop_change_irq);
		wait_lvl(hop_change_irq, 1'b1, 60);
		chk("dwell", 20'h1, 20'(waited + 4 >= 17 && waited + 4 <= 22));
		chk("index", 20'h2, current_hop_index);
		op_mode = sprhc_pkg::SPRHC_STDBY;
		step(3);
		clr(1'b1);
	endtask : t_hop_tx
	task automatic t_hop_rx;
		cfg(16'h000C, 1'b0, 4'h7, 3'h1, 8'h14, 1'b0, 8'h01);
		op_mode = sprhc_pkg::SPRHC_RX;
		step(30);
		chk("index_flag", 20'h0, {current_hop_index, hop_change_irq});
		i_sprhc_link_peer.pulse(3'h1, 4);
		i_sprhc_link_peer.pulse(3'h4, 4);
		step(10);
		chk("discards", 20'h1, 20'(discards));
		chk("index_flag", 20'h0, {current_hop_index, hop_change_irq});
		i_sprhc_link_peer.pulse(3'h1, 4);
		i_sprhc_link_peer.pulse(3'h2, 4);
		wait_lvl(hop_change_irq, 1'b1, 200);
		chk("index", 20'h1, current_hop_index);
		op_mode = sprhc_pkg::SPRHC_STDBY;
		step(3);
	endtask : t_hop_rx
	task automatic test_done;
		if (mismatches == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	////////////////////////////////////////
	initial begin
		{clk, link_clk, sys_rst, fsk_mode, auto_top_sequencer_req, cfg_we} = 6'h08;
		op_mode = sprhc_pkg::SPRHC_SLEEP;
		{cfg_no_header_select, cfg_crc_on, cfg_slow_rate_robustness, irq_clr_we} = '0;
		{irq_clr_data, buffer_pointer_we, buffer_port_wr, buffer_port_rd, rx_byte_we} = '0;
		{cfg_preamble_len_high, cfg_preamble_len_low, cfg_payload_len, cfg_hop_dwell_field} = '0;
		{buffer_pointer_wdata, buffer_port_wdata, rx_byte_addr, rx_byte_data} = '0;
		{cfg_spread_factor, cfg_coding_rate_code} = '0;
		{mismatches, samples_checked, discards} = '0;
		step(4);
		sys_rst = 1'b0;
		t_reset;
		t_header;
		t_airtime;
		t_fsk;
		t_buffer;
		t_hop_tx;
		t_hop_rx;
		test_done;
	end
	initial begin
		#1_000_000;
		mismatches++;
		test_done;
	end
endmodule : sprhc_top_tb
`default_nettype wire
